// ==== logic/slb_pkg.sv ====
package slb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] SYNC_CONTROL_ADR       = 10'h03A;
  localparam logic [ADDR_W-1:0] SYNC_LOCK_STATUS_ADR   = 10'h03B;
  localparam logic [ADDR_W-1:0] CDR_RESET_CONTROL_ADR  = 10'h206;
  localparam logic [ADDR_W-1:0] CDR_CLOCKING_CONFIG_ADR = 10'h230;
  localparam logic [ADDR_W-1:0] EQUALIZER_CONFIG_ADR   = 10'h268;
  localparam logic [ADDR_W-1:0] SERIAL_PLL_ENABLE_ADR  = 10'h280;
  localparam logic [ADDR_W-1:0] SERIAL_PLL_STATUS_ADR  = 10'h281;
  localparam logic [ADDR_W-1:0] SERIAL_PLL_DIVIDER_ADR = 10'h289;
  localparam logic [ADDR_W-1:0] PHY_AUTOTUNE_ADR       = 10'h2A7;
  localparam logic [ADDR_W-1:0] LINK_CONTROL_ADR       = 10'h300;
  localparam logic [ADDR_W-1:0] LINK_SUBCLASS_ADR      = 10'h301;
  localparam logic [ADDR_W-1:0] MULTIFRAME_DELAY_ADR   = 10'h304;
  localparam logic [ADDR_W-1:0] MULTIFRAME_WINDOW_ADR  = 10'h306;
  localparam logic [ADDR_W-1:0] LANE_CROSSBAR_LOW_ADR  = 10'h308;
  localparam logic [ADDR_W-1:0] LANE_CROSSBAR_HIGH_ADR = 10'h309;
  localparam logic [ADDR_W-1:0] SERIAL_PORT_CONFIG_ADR = 10'h314;
  localparam logic [ADDR_W-1:0] LANE_POLARITY_ADR      = 10'h334;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CDR_HALF_RATE_BIT  = 5;
  localparam int CDR_PLL_CFG_HI     = 4;
  localparam int CDR_PLL_CFG_LO     = 2;
  localparam int CDR_OVERSAMPLE_BIT = 1;
  localparam int CDR_SWING_BIT      = 0;
  localparam int PLL_DIV_CFG_BIT    = 2;
  localparam int PLL_DIV_HI         = 1;
  localparam int EQ_SEL_HI          = 7;
  localparam int EQ_SEL_LO          = 6;
  localparam int PLL_ENABLE_BIT     = 0;
  localparam int PLL_LOCK_BIT       = 0;
  localparam int CDR_RELEASE_BIT    = 0;
  localparam int SYNC_ENABLE_BIT    = 7;
  localparam int SYNC_ARM_BIT       = 6;
  localparam int SYNC_MODE_HI       = 2;
  localparam int SYNC_LOCK_BIT      = 3;
  localparam int LINK_CHECKSUM_BIT  = 6;
  localparam int LINK_ENABLE_BIT    = 0;
  localparam int SUBCLASS_HI        = 2;
  localparam int XBAR_FIELD_W       = 3;
  localparam int XBAR_FIELD_1_LO    = 3;

  // ----------------------------------------------------------------
  // Modes, reset values, sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_MODE_ONE_SHOT   = 3'h1;
  localparam logic [2:0] SYNC_MODE_CONTINUOUS = 3'h2;
  localparam logic [7:0] BYTE_ZERO            = 8'h00;
  localparam logic [7:0] CDR_CLOCKING_RST     = 8'h08;
  localparam logic [7:0] EQUALIZER_RST        = 8'h22;
  localparam logic [7:0] PLL_DIVIDER_RST      = 8'h04;
  localparam logic [7:0] XBAR_LOW_RST         = 8'h08;
  localparam logic [7:0] XBAR_HIGH_RST        = 8'h1A;
  localparam int NUM_LANES = 4;
  localparam int LANE_W    = 10;

  // ----------------------------------------------------------------
  // Serial port framing and timing
  // ----------------------------------------------------------------
  localparam int SPI_CNT_W       = 5;
  localparam logic [SPI_CNT_W-1:0] SPI_INSTR_LAST = 5'h0F;
  localparam logic [SPI_CNT_W-1:0] SPI_DATA_FIRST = 5'h10;
  localparam logic [SPI_CNT_W-1:0] SPI_FRAME_LAST = 5'h17;
  localparam logic [SPI_CNT_W-1:0] SPI_FRAME_END  = 5'h18;
  localparam int SPI_RW_BIT = 15;

  localparam int CLK_PERIOD_NS    = 50;
  localparam int PLL_LOCK_TIME_NS = 100000;
  localparam int PLL_LOCK_CYC     = (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_CNT_W        = 12;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  wr;
    logic [ADDR_W-1:0]     addr;
    logic [7:0]            wdata;
  } slb_req_t;

  typedef struct packed {
    logic       half_rate;
    logic       cdr_oversample_select;
    logic       sync_swing_350mv;
    logic [1:0] serial_clock_divider_select;
    logic [1:0] equalizer_select;
    logic       cdr_in_reset;
    logic       serial_pll_locked;
  } slb_phy_cfg_t;

  typedef struct packed {
    logic                 link_enable;
    logic                 config_checksum_method;
    logic [2:0]           subclass;
    logic [7:0]           multiframe_delay_setting;
    logic [7:0]           multiframe_variance_window;
    logic [NUM_LANES-1:0] lane_polarity_invert;
    logic                 multiframe_locked;
  } slb_link_cfg_t;

endpackage

// ==== logic/slb_spi_slave.sv ====
`timescale 1ns/10ps
module slb_spi_slave
  import slb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_csb_n,
  input  wire logic        spi_sdio_in,
  input  wire logic [7:0]  rdata,
  output logic             sdio_out,
  output logic             sdio_oe_n,
  output slb_req_t         req
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1_q, s2_q;
  logic       sclk_prev_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // Idle levels: deselected, clock low
      s1_q        <= 3'h4;
      s2_q        <= 3'h4;
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q        <= {spi_csb_n, spi_sclk, spi_sdio_in};
      s2_q        <= s1_q;
      sclk_prev_q <= s2_q[1];
    end
  end

  logic csb_n, rise, fall;
  assign csb_n = s2_q[2];
  assign rise  = s2_q[1] & ~sclk_prev_q;
  assign fall  = ~s2_q[1] & sclk_prev_q;

  // ----------------------------------------------------------------
  // Frame: 16-bit instruction, then one data byte, MSB first
  // ----------------------------------------------------------------
  logic [SPI_CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0]          sh_q, sh_d;
  logic                 rd_q, rd_d;
  logic [7:0]           out_q, out_d;
  logic                 sdo_q, sdo_d, oe_n_q, oe_n_d;
  slb_req_t             req_q, req_d;

  always_comb begin
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    rd_d   = rd_q;
    out_d  = out_q;
    sdo_d  = sdo_q;
    oe_n_d = oe_n_q;
    req_d  = req_q;
    req_d.wr = 1'b0;
    if (csb_n) begin
      cnt_d  = '0;
      oe_n_d = 1'b1;
    end else if (rise && cnt_q < SPI_FRAME_END) begin
      sh_d  = {sh_q[14:0], s2_q[0]};
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == SPI_INSTR_LAST) begin
        rd_d       = sh_d[SPI_RW_BIT];
        req_d.addr = sh_d[ADDR_W-1:0];
      end
      if (cnt_q == SPI_FRAME_LAST && !rd_q) begin
        req_d.wr    = 1'b1;
        req_d.wdata = sh_d[7:0];
      end
    end else if (fall && rd_q) begin
      if (cnt_q == SPI_DATA_FIRST) begin
        out_d  = {rdata[6:0], 1'b0};
        sdo_d  = rdata[7];
        oe_n_d = 1'b0;
      end else if (cnt_q == SPI_FRAME_END) begin
        oe_n_d = 1'b1;
      end else if (cnt_q > SPI_DATA_FIRST) begin
        sdo_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q  <= '0;
      sh_q   <= '0;
      rd_q   <= 1'b0;
      out_q  <= '0;
      sdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
      req_q  <= '0;
    end else begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      out_q  <= out_d;
      sdo_q  <= sdo_d;
      oe_n_q <= oe_n_d;
      req_q  <= req_d;
    end
  end

  assign sdio_out  = sdo_q;
  assign sdio_oe_n = oe_n_q;
  assign req       = req_q;

endmodule

// ==== logic/slb_sysref_sync.sv ====
`timescale 1ns/10ps
module slb_sysref_sync
  import slb_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic sysref_in,
  input  wire logic sync_enable,
  input  wire logic sync_armed,
  output logic      mf_locked,
  output logic      edge_taken
);

  // ----------------------------------------------------------------
  // Reference edge capture
  // ----------------------------------------------------------------
  logic ref1_q, ref2_q, ref3_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ref1_q <= 1'b0;
      ref2_q <= 1'b0;
      ref3_q <= 1'b0;
    end else begin
      ref1_q <= sysref_in;
      ref2_q <= ref1_q;
      ref3_q <= ref2_q;
    end
  end

  // ----------------------------------------------------------------
  // Lock flag; a disable beats a capture in the same cycle
  // ----------------------------------------------------------------
  logic lock_q, lock_d, take_q, take_d;
  always_comb begin
    take_d = sync_enable & sync_armed & ref2_q & ~ref3_q;
    lock_d = lock_q;
    if (!sync_enable) begin
      lock_d = 1'b0;
    end
    if (take_d) begin
      lock_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
      take_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
      take_q <= take_d;
    end
  end

  assign mf_locked  = lock_q;
  assign edge_taken = take_q;

endmodule

// ==== logic/slb_top.sv ====
// Operation
// - CDR clocking holds half-rate and oversample bits
// - CDR bit 0 selects 350 mV sync swing
// - Divider bit 2 set; bits 1:0 serial clock divider
// - PLL enable leads to lock status bit 0
// - Equalizer select bits 7:6; low bits 0x22
// - Sync control 0x01 selects one-shot alignment
// - Sync control 0x81 enables the sync machine
// - Sync control 0xC1 arms for next edge
// - Sync status bit 3 shows multiframe lock
// - Crossbar maps physical lanes to logical lanes
// - Polarity bit x inverts logical lane x
// - Link control: bit 6 checksum, bit 0 enable
`timescale 1ns/10ps
module slb_top
  import slb_pkg::*;
(
  input  wire logic                                core_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                spi_sclk,
  input  wire logic                                spi_csb_n,
  input  wire logic                                spi_sdio_in,
  output logic                                     spi_sdio_out,
  output logic                                     spi_sdio_oe_n,
  input  wire logic                                sysref_in,
  input  wire logic [NUM_LANES-1:0][LANE_W-1:0]    phy_lane_data,
  output logic      [NUM_LANES-1:0][LANE_W-1:0]    logical_lane_data,
  output slb_phy_cfg_t                             phy_cfg,
  output slb_link_cfg_t                            link_cfg,
  output logic                                     lmfc_align
);

  // ----------------------------------------------------------------
  // Serial control port and reference sync machine
  // ----------------------------------------------------------------
  slb_req_t   req;
  logic [7:0] rdata;
  logic       mf_locked;
  logic       edge_taken;
  logic [7:0] sync_ctrl_q, sync_ctrl_d;

  slb_spi_slave u_spi (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .spi_sclk    (spi_sclk),
    .spi_csb_n   (spi_csb_n),
    .spi_sdio_in (spi_sdio_in),
    .rdata       (rdata),
    .sdio_out    (spi_sdio_out),
    .sdio_oe_n   (spi_sdio_oe_n),
    .req         (req)
  );

  slb_sysref_sync u_sync (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .sysref_in   (sysref_in),
    .sync_enable (sync_ctrl_q[SYNC_ENABLE_BIT]),
    .sync_armed  (sync_ctrl_q[SYNC_ARM_BIT]),
    .mf_locked   (mf_locked),
    .edge_taken  (edge_taken)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] autotune_q, autotune_d;
  logic [7:0] serport_q, serport_d;
  logic [7:0] cdr_clk_q, cdr_clk_d;
  logic [7:0] cdr_rst_q, cdr_rst_d;
  logic [7:0] eq_q, eq_d;
  logic [7:0] pll_en_q, pll_en_d;
  logic [7:0] pll_div_q, pll_div_d;
  logic [7:0] link_ctrl_q, link_ctrl_d;
  logic [7:0] subclass_q, subclass_d;
  logic [7:0] mf_delay_q, mf_delay_d;
  logic [7:0] mf_window_q, mf_window_d;
  logic [7:0] xbar_lo_q, xbar_lo_d;
  logic [7:0] xbar_hi_q, xbar_hi_d;
  logic [7:0] polarity_q, polarity_d;

  function automatic logic hit(input slb_req_t r, input logic [ADDR_W-1:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  always_comb begin
    autotune_d  = hit(req, PHY_AUTOTUNE_ADR)        ? req.wdata : autotune_q;
    serport_d   = hit(req, SERIAL_PORT_CONFIG_ADR)  ? req.wdata : serport_q;
    cdr_clk_d   = hit(req, CDR_CLOCKING_CONFIG_ADR) ? req.wdata : cdr_clk_q;
    cdr_rst_d   = hit(req, CDR_RESET_CONTROL_ADR)   ? req.wdata : cdr_rst_q;
    eq_d        = hit(req, EQUALIZER_CONFIG_ADR)    ? req.wdata : eq_q;
    pll_en_d    = hit(req, SERIAL_PLL_ENABLE_ADR)   ? req.wdata : pll_en_q;
    pll_div_d   = hit(req, SERIAL_PLL_DIVIDER_ADR)  ? req.wdata : pll_div_q;
    link_ctrl_d = hit(req, LINK_CONTROL_ADR)        ? req.wdata : link_ctrl_q;
    subclass_d  = hit(req, LINK_SUBCLASS_ADR)       ? req.wdata : subclass_q;
    mf_delay_d  = hit(req, MULTIFRAME_DELAY_ADR)    ? req.wdata : mf_delay_q;
    mf_window_d = hit(req, MULTIFRAME_WINDOW_ADR)   ? req.wdata : mf_window_q;
    xbar_lo_d   = hit(req, LANE_CROSSBAR_LOW_ADR)   ? req.wdata : xbar_lo_q;
    xbar_hi_d   = hit(req, LANE_CROSSBAR_HIGH_ADR)  ? req.wdata : xbar_hi_q;
    polarity_d  = hit(req, LANE_POLARITY_ADR)       ? req.wdata : polarity_q;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      autotune_q  <= BYTE_ZERO;
      serport_q   <= BYTE_ZERO;
      cdr_clk_q   <= CDR_CLOCKING_RST;
      cdr_rst_q   <= BYTE_ZERO;
      eq_q        <= EQUALIZER_RST;
      pll_en_q    <= BYTE_ZERO;
      pll_div_q   <= PLL_DIVIDER_RST;
      link_ctrl_q <= BYTE_ZERO;
      subclass_q  <= BYTE_ZERO;
      mf_delay_q  <= BYTE_ZERO;
      mf_window_q <= BYTE_ZERO;
      xbar_lo_q   <= XBAR_LOW_RST;
      xbar_hi_q   <= XBAR_HIGH_RST;
      polarity_q  <= BYTE_ZERO;
    end else begin
      autotune_q  <= autotune_d;
      serport_q   <= serport_d;
      cdr_clk_q   <= cdr_clk_d;
      cdr_rst_q   <= cdr_rst_d;
      eq_q        <= eq_d;
      pll_en_q    <= pll_en_d;
      pll_div_q   <= pll_div_d;
      link_ctrl_q <= link_ctrl_d;
      subclass_q  <= subclass_d;
      mf_delay_q  <= mf_delay_d;
      mf_window_q <= mf_window_d;
      xbar_lo_q   <= xbar_lo_d;
      xbar_hi_q   <= xbar_hi_d;
      polarity_q  <= polarity_d;
    end
  end

  // ----------------------------------------------------------------
  // Sync control: software write wins over the hardware disarm
  // ----------------------------------------------------------------
  logic one_shot;
  assign one_shot = (sync_ctrl_q[SYNC_MODE_HI:0] == SYNC_MODE_ONE_SHOT);

  always_comb begin
    sync_ctrl_d = sync_ctrl_q;
    if (hit(req, SYNC_CONTROL_ADR)) begin
      sync_ctrl_d = req.wdata;
    end else if (edge_taken && one_shot) begin
      sync_ctrl_d[SYNC_ARM_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_ctrl_q <= BYTE_ZERO;
    end else begin
      sync_ctrl_q <= sync_ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial PLL lock model
  // ----------------------------------------------------------------
  // Any change to clocking setup restarts the lock wait, as a real
  // loop would lose lock when its divider moves.
  logic [PLL_CNT_W-1:0] lock_cnt_q, lock_cnt_d;
  logic                 pll_lock_q, pll_lock_d;
  logic                 pll_run;

  assign pll_run = pll_en_q[PLL_ENABLE_BIT] & cdr_rst_q[CDR_RELEASE_BIT]
                   & pll_div_q[PLL_DIV_CFG_BIT];

  always_comb begin
    lock_cnt_d = lock_cnt_q;
    pll_lock_d = pll_lock_q;
    if (!pll_run || hit(req, SERIAL_PLL_DIVIDER_ADR) || hit(req, CDR_CLOCKING_CONFIG_ADR)) begin
      lock_cnt_d = '0;
      pll_lock_d = 1'b0;
    end else if (lock_cnt_q == PLL_CNT_W'(PLL_LOCK_CYC - 1)) begin
      pll_lock_d = 1'b1;
    end else begin
      lock_cnt_d = lock_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lock_cnt_q <= '0;
      pll_lock_q <= 1'b0;
    end else begin
      lock_cnt_q <= lock_cnt_d;
      pll_lock_q <= pll_lock_d;
    end
  end

  // ----------------------------------------------------------------
  // CDR hold flag
  // ----------------------------------------------------------------
  // Own flop so the output needs no inverter behind the register;
  // it always mirrors the inverse of the release bit.
  logic cdr_hold_q, cdr_hold_d;

  always_comb begin
    cdr_hold_d = ~cdr_rst_d[CDR_RELEASE_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cdr_hold_q <= 1'b1;
    end else begin
      cdr_hold_q <= cdr_hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_comb begin
    case (req.addr)
      SYNC_CONTROL_ADR:        rdata = sync_ctrl_q;
      SYNC_LOCK_STATUS_ADR:    rdata = 8'(mf_locked) << SYNC_LOCK_BIT;
      CDR_RESET_CONTROL_ADR:   rdata = cdr_rst_q;
      CDR_CLOCKING_CONFIG_ADR: rdata = cdr_clk_q;
      EQUALIZER_CONFIG_ADR:    rdata = eq_q;
      SERIAL_PLL_ENABLE_ADR:   rdata = pll_en_q;
      SERIAL_PLL_STATUS_ADR:   rdata = 8'(pll_lock_q) << PLL_LOCK_BIT;
      SERIAL_PLL_DIVIDER_ADR:  rdata = pll_div_q;
      PHY_AUTOTUNE_ADR:        rdata = autotune_q;
      LINK_CONTROL_ADR:        rdata = link_ctrl_q;
      LINK_SUBCLASS_ADR:       rdata = subclass_q;
      MULTIFRAME_DELAY_ADR:    rdata = mf_delay_q;
      MULTIFRAME_WINDOW_ADR:   rdata = mf_window_q;
      LANE_CROSSBAR_LOW_ADR:   rdata = xbar_lo_q;
      LANE_CROSSBAR_HIGH_ADR:  rdata = xbar_hi_q;
      SERIAL_PORT_CONFIG_ADR:  rdata = serport_q;
      LANE_POLARITY_ADR:       rdata = polarity_q;
      default:                 rdata = BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Lane crossbar and polarity
  // ----------------------------------------------------------------
  // Only the low two bits of each 3-bit crossbar field index a lane.
  logic [NUM_LANES-1:0][LANE_W-1:0] lane_q, lane_d;
  logic [NUM_LANES-1:0][1:0]        sel;
  logic                             align_q, align_d;

  assign sel[0] = xbar_lo_q[1:0];
  assign sel[1] = xbar_lo_q[XBAR_FIELD_1_LO +: 2];
  assign sel[2] = xbar_hi_q[1:0];
  assign sel[3] = xbar_hi_q[XBAR_FIELD_1_LO +: 2];

  always_comb begin
    lane_d  = '0;
    align_d = edge_taken;
    if (link_ctrl_q[LINK_ENABLE_BIT]) begin
      for (int x = 0; x < NUM_LANES; x++) begin
        lane_d[x] = phy_lane_data[sel[x]]
                    ^ {LANE_W{polarity_q[x]}};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lane_q  <= '0;
      align_q <= 1'b0;
    end else begin
      lane_q  <= lane_d;
      align_q <= align_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign logical_lane_data = lane_q;
  assign lmfc_align        = align_q;

  assign phy_cfg.half_rate                   = cdr_clk_q[CDR_HALF_RATE_BIT];
  assign phy_cfg.cdr_oversample_select       = cdr_clk_q[CDR_OVERSAMPLE_BIT];
  assign phy_cfg.sync_swing_350mv            = cdr_clk_q[CDR_SWING_BIT];
  assign phy_cfg.serial_clock_divider_select = pll_div_q[PLL_DIV_HI:0];
  assign phy_cfg.equalizer_select            = eq_q[EQ_SEL_HI:EQ_SEL_LO];
  assign phy_cfg.cdr_in_reset                = cdr_hold_q;
  assign phy_cfg.serial_pll_locked           = pll_lock_q;

  assign link_cfg.link_enable                = link_ctrl_q[LINK_ENABLE_BIT];
  assign link_cfg.config_checksum_method     = link_ctrl_q[LINK_CHECKSUM_BIT];
  assign link_cfg.subclass                   = subclass_q[SUBCLASS_HI:0];
  assign link_cfg.multiframe_delay_setting   = mf_delay_q;
  assign link_cfg.multiframe_variance_window = mf_window_q;
  assign link_cfg.lane_polarity_invert       = polarity_q[NUM_LANES-1:0];
  assign link_cfg.multiframe_locked          = mf_locked;

endmodule

// ==== verification/slb_chk_properties.sv ====
`timescale 1ns/10ps
module slb_chk
  import slb_pkg::*;
(
  input wire logic                             core_clk,
  input wire logic                             sys_rst,
  input wire logic                             spi_csb_n,
  input wire logic                             spi_sdio_oe_n,
  input wire logic                             sysref_in,
  input wire logic [NUM_LANES-1:0][LANE_W-1:0] logical_lane_data,
  input wire slb_phy_cfg_t                     phy_cfg,
  input wire slb_link_cfg_t                    link_cfg,
  input wire logic                             lmfc_align
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> phy_cfg == 9'h002 && link_cfg == '0; endproperty
  a_rst: assert property (p_rst) else $error("config not at reset");
  property p_off; !$past(link_cfg.link_enable) |-> logical_lane_data == '0; endproperty
  a_off: assert property (p_off) else $error("lanes live while off");
  property p_pulse; $rose(link_cfg.multiframe_locked) |=> lmfc_align; endproperty
  a_pulse: assert property (p_pulse) else $error("no align pulse");
  property p_one; lmfc_align |=> !lmfc_align; endproperty
  a_one: assert property (p_one) else $error("align pulse too long");
  property p_held; lmfc_align |-> link_cfg.multiframe_locked; endproperty
  a_held: assert property (p_held) else $error("pulse without lock");
  property p_cause; lmfc_align |-> $past(sysref_in, 2); endproperty
  a_cause: assert property (p_cause) else $error("pulse without edge");
  property p_pll; $rose(phy_cfg.serial_pll_locked) |-> !phy_cfg.cdr_in_reset; endproperty
  a_pll: assert property (p_pll) else $error("lock while cdr held");
  // Deselected port must leave the shared data pin free
  property p_oe; spi_csb_n [*5] |-> spi_sdio_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("pin driven while idle");
endmodule
bind slb_top slb_chk slb_chk_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .spi_csb_n(spi_csb_n),
  .spi_sdio_oe_n(spi_sdio_oe_n), .sysref_in(sysref_in), .phy_cfg(phy_cfg),
  .logical_lane_data(logical_lane_data), .link_cfg(link_cfg), .lmfc_align(lmfc_align)
);

// ==== verification/slb_tx_model.sv ====
`timescale 1ns/10ps
module slb_tx_model
  import slb_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        send_edge,
  output logic                             sysref_in,
  output logic [NUM_LANES-1:0][LANE_W-1:0] phy_lane_data
);
  logic [3:0] sr_q;
  logic [7:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sr_q  <= 4'h0;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      if (send_edge) begin
        sr_q <= 4'h8;
      end else if (sr_q != 4'h0) begin
        sr_q <= sr_q - 4'h1;
      end
    end
  end
  assign sysref_in = (sr_q != 4'h0);
  // Symbols change every cycle so a stale or swapped lane shows
  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      phy_lane_data[i] = {cnt_q ^ 8'(i * 53), 2'(i)};
    end
  end
endmodule

// ==== verification/serial_link_bringup_config_tb_top.sv ====
`timescale 1ns/10ps
module serial_link_bringup_config_tb_top
  import slb_pkg::*;
;
  logic core_clk = 1'b0, sys_rst = 1'b1, spi_sclk = 1'b0, spi_csb_n = 1'b1;
  logic host_d = 1'b0, send_edge = 1'b0;
  wire  spi_sdio_in, spi_sdio_out, spi_sdio_oe_n, sysref_in, lmfc_align;
  wire  [NUM_LANES-1:0][LANE_W-1:0] phy_lane_data, logical_lane_data;
  slb_phy_cfg_t  phy_cfg;
  slb_link_cfg_t link_cfg;
  int n_fail = 0, samples_checked = 0, n_pulse = 0;
  logic [9:0] adr [17] = '{10'h03A, 10'h03B, 10'h206, 10'h230, 10'h268, 10'h280, 10'h281,
    10'h289, 10'h2A7, 10'h300, 10'h301, 10'h304, 10'h306, 10'h308, 10'h309, 10'h314, 10'h334};
  logic [7:0] rv [17] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h22, 8'h00, 8'h00, 8'h04, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h1A, 8'h00, 8'h00};
  slb_top slb_top_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_n(spi_sdio_oe_n),
    .sysref_in(sysref_in), .phy_lane_data(phy_lane_data), .lmfc_align(lmfc_align),
    .logical_lane_data(logical_lane_data), .phy_cfg(phy_cfg), .link_cfg(link_cfg)
  );
  slb_tx_model slb_tx_model_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .send_edge(send_edge),
    .sysref_in(sysref_in), .phy_lane_data(phy_lane_data)
  );
  always #25 core_clk = ~core_clk;
  // Shared data pin: device wins while it enables its driver
  assign spi_sdio_in = spi_sdio_oe_n ? host_d : spi_sdio_out;
  always @(posedge core_clk) if (lmfc_align === 1'b1) n_pulse++;
  task automatic clks(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Six-cycle levels keep sampling clear of the pin resync delay
  task automatic xfer(input logic [23:0] f, output logic [7:0] rd);
    spi_csb_n <= 1'b0;
    clks(4);
    for (int i = 23; i >= 0; i--) begin
      host_d <= f[i];
      spi_sclk <= 1'b0;
      clks(6);
      if (i < 8) rd[i] = spi_sdio_out;
      spi_sclk <= 1'b1;
      clks(6);
    end
    spi_sclk <= 1'b0;
    clks(6);
    spi_csb_n <= 1'b1;
    clks(8);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] v;
    xfer({6'h00, a, d}, v);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] v;
    xfer({6'h20, a, 8'h00}, v);
    cmp(v, e);
  endtask
  task automatic edge_out;
    send_edge <= 1'b1;
    clks(1);
    send_edge <= 1'b0;
    clks(20);
  endtask
  task automatic lane_chk(input logic [3:0] pol, input int m [4]);
    logic [NUM_LANES-1:0][LANE_W-1:0] p, e;
    @(posedge core_clk);
    #1 p = phy_lane_data;
    repeat (3) begin
      @(posedge core_clk);
      #1;
      for (int x = 0; x < 4; x++) e[x] = p[m[x]] ^ {LANE_W{pol[x]}};
      cmp(logical_lane_data, e);
      p = phy_lane_data;
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clks(4);
    sys_rst <= 1'b0;
    clks(3);
    for (int i = 0; i < 17; i++) rdc(adr[i], rv[i]);
    rdc(10'h100, 8'h00);
    for (int i = 0; i < 17; i++) wr(adr[i], 8'h5A);
    for (int i = 0; i < 17; i++) rdc(adr[i], (i == 1 || i == 6) ? 8'h00 : 8'h5A);
    sys_rst <= 1'b1;
    clks(4);
    sys_rst <= 1'b0;
    clks(3);
    wr(10'h2A7, 8'h01);
    wr(10'h314, 8'h01);
    wr(10'h230, 8'h2B);
    wr(10'h206, 8'h00);
    cmp(phy_cfg.cdr_in_reset, 1'b1);
    wr(10'h206, 8'h01);
    wr(10'h289, 8'h05);
    wr(10'h268, 8'hA2);
    wr(10'h280, 8'h01);
    cmp(phy_cfg, 9'h1D8);
    clks(2000);
    rdc(10'h281, 8'h01);
    wr(10'h301, 8'h01);
    wr(10'h304, 8'h11);
    wr(10'h306, 8'h03);
    wr(10'h03A, 8'h01);
    wr(10'h03A, 8'h81);
    rdc(10'h03B, 8'h00);
    wr(10'h03A, 8'hC1);
    edge_out();
    rdc(10'h03B, 8'h08);
    rdc(10'h03A, 8'h81);
    edge_out();
    cmp(n_pulse, 1);
    wr(10'h03A, 8'hC2);
    edge_out();
    edge_out();
    cmp(n_pulse, 3);
    rdc(10'h03A, 8'hC2);
    wr(10'h03A, 8'h02);
    rdc(10'h03B, 8'h00);
    wr(10'h308, 8'h13);
    wr(10'h309, 8'h01);
    wr(10'h334, 8'h05);
    wr(10'h300, 8'h41);
    cmp(link_cfg, {1'b1, 1'b1, 3'h1, 8'h11, 8'h03, 4'h5, 1'b0});
    lane_chk(4'h5, '{3, 2, 1, 0});
    wr(10'h300, 8'h40);
    cmp(logical_lane_data, 40'h0);
    summarize();
  end
  initial begin
    clks(40000);
    n_fail++;
    summarize();
  end
endmodule
